// ==== rtl/pcdf_filter.sv ====
// Eight-channel input debounce filter with per-channel delay and mode.
`timescale 1ns/1ps
`default_nettype none
`include "pcdf_params.svh"

module pcdf_filter #(
   parameter int         NUM_CH      = 8,
   parameter logic [7:0] HS_MASK     = 8'h00,
   parameter bit         SERIAL_CFG  = 1'b1,
   parameter logic [1:0] FIXED_DELAY = 2'h0,
   parameter int         TICK_CYCLES = `PCDF_TICK_CYC
) (
   // Clock and reset.
   input  wire logic                                mclk,
   input  wire logic                                sys_rst,
   // Raw field inputs, asynchronous to mclk.
   input  wire logic [NUM_CH-1:0]                   field_in,
   // Register access from the host interface logic.
   input  wire pcdf_pkg::pcdf_reg_req_t             reg_req,
   output var  pcdf_pkg::pcdf_reg_rsp_t             reg_rsp,
   // Filtered channel levels.
   output wire logic [NUM_CH-1:0]                   filtered_levels,
   // Configuration in force for each channel.
   output wire pcdf_pkg::pcdf_chan_cfg_t [NUM_CH-1:0] chan_cfg
);

   // Widths of the tick prescaler and the fixed-stage counter.
   localparam int TW = $clog2(TICK_CYCLES + 1) + 1;
   localparam int LP = `PCDF_LP_CYC;
   localparam int LW = $clog2(LP + 1) + 1;

   // Refuse settings the logic cannot serve.
   generate
      if (NUM_CH != 8 || TICK_CYCLES < 1 || LP < 1) begin : g_bad_param
         $error("pcdf_filter: NUM_CH must be 8 and cycle counts at least 1.");
      end
   endgenerate

   // Turns a delay code into a count of millisecond ticks.
   function automatic logic [6:0] delay_ticks(input logic [1:0] code);
      logic [6:0] t;
      t = `PCDF_DLY0_MS;
      case (code)
         2'h0:    t = `PCDF_DLY0_MS;
         2'h1:    t = `PCDF_DLY1_MS;
         2'h2:    t = `PCDF_DLY2_MS;
         2'h3:    t = `PCDF_DLY3_MS;
         default: t = `PCDF_DLY0_MS;
      endcase
      return t;
   endfunction : delay_ticks

   // Turns a mode code into a filter mode; the low bit is ignored when the top bit is set.
   function automatic pcdf_pkg::pcdf_mode_t mode_of(input logic [1:0] code);
      pcdf_pkg::pcdf_mode_t m;
      m = pcdf_pkg::PCDF_DEGLITCH;
      case (code)
         2'h0:    m = pcdf_pkg::PCDF_DEGLITCH;
         2'h1:    m = pcdf_pkg::PCDF_LOWPASS;
         2'h2:    m = pcdf_pkg::PCDF_BLANKING;
         2'h3:    m = pcdf_pkg::PCDF_BLANKING;
         default: m = pcdf_pkg::PCDF_DEGLITCH;
      endcase
      return m;
   endfunction : mode_of

   // Two-stage synchroniser on the field inputs. No reset, so the
   // outputs can load a settled input level while reset is held.
   logic [NUM_CH-1:0] sync_a_reg;
   logic [NUM_CH-1:0] sync_b_reg;

   always_ff @(posedge mclk)
   begin
      sync_a_reg <= field_in;
      sync_b_reg <= sync_a_reg;
   end

   // Millisecond tick. A single shared prescaler keeps area small, at the
   // cost of up to one tick of jitter on every nonzero selected delay.
   logic [TW-1:0] tick_cnt_reg;
   logic          tick_reg;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end
      else if (tick_cnt_reg == TW'(TICK_CYCLES - 1))
      begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
         tick_reg     <= 1'b0;
      end
   end

   // Configuration registers, eight bits each.
   logic [7:0] filter_select_low_reg;
   logic [7:0] filter_select_high_reg;
   logic [7:0] delay_select_low_reg;
   logic [7:0] delay_select_high_reg;

   // Register writes; an unmapped offset changes nothing.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         filter_select_low_reg  <= `PCDF_CFG_RST;
         filter_select_high_reg <= `PCDF_CFG_RST;
         delay_select_low_reg   <= `PCDF_CFG_RST;
         delay_select_high_reg  <= `PCDF_CFG_RST;
      end
      else if (reg_req.wr_en && SERIAL_CFG)
      begin
         case (reg_req.addr)
            `PCDF_ADDR_SEL_LOW:  filter_select_low_reg  <= reg_req.wdata;
            `PCDF_ADDR_SEL_HIGH: filter_select_high_reg <= reg_req.wdata;
            `PCDF_ADDR_DLY_LOW:  delay_select_low_reg   <= reg_req.wdata;
            `PCDF_ADDR_DLY_HIGH: delay_select_high_reg  <= reg_req.wdata;
            default:             filter_select_low_reg  <= filter_select_low_reg;
         endcase
      end
   end

   // Register reads answer one cycle after the request. The status
   // register ignores writes; unmapped offsets read as zero.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         reg_rsp <= '0;
      end
      else
      begin
         reg_rsp.rd_valid <= reg_req.rd_en;
         if (reg_req.rd_en)
         begin
            case (reg_req.addr)
               `PCDF_ADDR_STATUS:   reg_rsp.rd_data <= filtered_levels;
               `PCDF_ADDR_SEL_LOW:  reg_rsp.rd_data <= filter_select_low_reg;
               `PCDF_ADDR_SEL_HIGH: reg_rsp.rd_data <= filter_select_high_reg;
               `PCDF_ADDR_DLY_LOW:  reg_rsp.rd_data <= delay_select_low_reg;
               `PCDF_ADDR_DLY_HIGH: reg_rsp.rd_data <= delay_select_high_reg;
               default:             reg_rsp.rd_data <= `PCDF_RD_UNMAPPED;
            endcase
         end
      end
   end

   // Per-channel filters.
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         localparam int FLD = (ch % `PCDF_CH_PER_REG) * `PCDF_FLD_W;

         logic [7:0] sel_word;
         logic [7:0] dly_word;

         // Channels 0..3 sit in the low registers, the highest channel on top.
         assign sel_word = (ch < `PCDF_CH_PER_REG) ? filter_select_low_reg
                                                   : filter_select_high_reg;
         assign dly_word = (ch < `PCDF_CH_PER_REG) ? delay_select_low_reg
                                                   : delay_select_high_reg;

         // Fixed variants ignore the registers and run the low-pass counter.
         if (SERIAL_CFG) begin : g_serial
            assign chan_cfg[ch].per_channel_filter_select = sel_word[FLD +: 2];
            assign chan_cfg[ch].per_channel_delay_select  = dly_word[FLD +: 2];
         end
         else begin : g_fixed
            assign chan_cfg[ch].per_channel_filter_select = 2'h1;
            assign chan_cfg[ch].per_channel_delay_select  = FIXED_DELAY;
         end

         if (HS_MASK[ch]) begin : g_fast
            // High-speed channels see only the synchroniser.
            assign filtered_levels[ch] = sync_b_reg[ch];
         end
         else begin : g_slow
            pcdf_pkg::pcdf_mode_t mode;
            logic [6:0]           tgt;
            logic [LW-1:0]        lp_cnt_reg;
            logic                 lp_out_reg;
            logic [6:0]           cnt_reg;
            logic                 last_reg;
            logic                 out_reg;
            logic                 changed;

            assign mode    = mode_of(chan_cfg[ch].per_channel_filter_select);
            assign tgt     = delay_ticks(chan_cfg[ch].per_channel_delay_select);
            assign changed = (lp_out_reg != last_reg);

            // Fixed low-pass stage ahead of the selectable one. It counts
            // cycles up while input and output differ and down otherwise.
            always_ff @(posedge mclk)
            begin
               if (sys_rst)
               begin
                  lp_cnt_reg <= '0;
                  lp_out_reg <= sync_b_reg[ch];
               end
               else if (sync_b_reg[ch] != lp_out_reg)
               begin
                  if (lp_cnt_reg >= LW'(LP - 1))
                  begin
                     lp_out_reg <= sync_b_reg[ch];
                     lp_cnt_reg <= '0;
                  end
                  else
                  begin
                     lp_cnt_reg <= lp_cnt_reg + LW'(1);
                  end
               end
               else if (lp_cnt_reg != '0)
               begin
                  lp_cnt_reg <= lp_cnt_reg - LW'(1);
               end
            end

            // Previous level of the fixed stage, used to see input changes.
            always_ff @(posedge mclk)
            begin
               if (sys_rst)
               begin
                  last_reg <= sync_b_reg[ch];
               end
               else
               begin
                  last_reg <= lp_out_reg;
               end
            end

            // Selectable stage. The counter is shared between modes; a mode
            // change mid-count simply carries the count over.
            always_ff @(posedge mclk)
            begin
               if (sys_rst)
               begin
                  cnt_reg <= 7'h00;
                  out_reg <= sync_b_reg[ch];
               end
               else
               begin
                  case (mode)
                     pcdf_pkg::PCDF_DEGLITCH:
                     begin
                        // Any movement restarts the stability count.
                        if (changed || lp_out_reg == out_reg)
                        begin
                           cnt_reg <= 7'h00;
                        end
                        else if (cnt_reg >= tgt)
                        begin
                           out_reg <= lp_out_reg;
                           cnt_reg <= 7'h00;
                        end
                        else if (tick_reg)
                        begin
                           cnt_reg <= cnt_reg + 7'h01;
                        end
                     end
                     pcdf_pkg::PCDF_LOWPASS:
                     begin
                        if (lp_out_reg != out_reg)
                        begin
                           if (cnt_reg >= tgt)
                           begin
                              out_reg <= lp_out_reg;
                              cnt_reg <= 7'h00;
                           end
                           else if (tick_reg)
                           begin
                              cnt_reg <= cnt_reg + 7'h01;
                           end
                        end
                        else if (tick_reg && cnt_reg != 7'h00)
                        begin
                           cnt_reg <= cnt_reg - 7'h01;
                        end
                     end
                     pcdf_pkg::PCDF_BLANKING:
                     begin
                        if (cnt_reg == 7'h00)
                        begin
                           // Blind time over: pass any difference at once.
                           if (lp_out_reg != out_reg)
                           begin
                              out_reg <= lp_out_reg;
                              cnt_reg <= tgt;
                           end
                        end
                        else if (changed)
                        begin
                           cnt_reg <= tgt;
                        end
                        else if (tick_reg)
                        begin
                           cnt_reg <= cnt_reg - 7'h01;
                        end
                     end
                     default:
                     begin
                        cnt_reg <= 7'h00;
                     end
                  endcase
               end
            end

            assign filtered_levels[ch] = out_reg;
         end
      end
   endgenerate

endmodule : pcdf_filter
`default_nettype wire

// ==== rtl/pcdf_params.svh ====
// Constants for the per-channel debounce filter: map, fields, resets, timing.
// Operation
// - Only low-speed channels are filtered; high-speed channels pass straight through.
// - Each of eight channels owns two delay bits and two mode bits.
// - Delay code 00 adds nothing, 01 10 ms, 10 30 ms, 11 100 ms.
// - Low-speed channels always have a fixed 4 us low-pass stage first.
// - Mode code 00 deglitch, 01 low-pass counter, 1X blanking.
// - Without serial configuration every low-speed channel is low-pass with fixed delay.
// - Deglitch output follows only after input is stable for the delay.
// - Low-pass counter counts up while input differs from output.
// - Low-pass counter counts down, not cleared, when input returns to output.
// - Low-pass count resumes upward from any remaining nonzero value.
// - Low-pass output switches when the counter reaches the delay.
// - Blanking counter starts at zero so the first change passes at once.
// - Blanking at zero count: output takes change, counter loads the delay.
// - Blanking counter decrements on ticks and reloads on each input change; output ignores input meanwhile.
// - Blanking at zero: differing input updates the output immediately.
// - Blanking at zero with match: next input change passes without delay.
// - Blanking: every input change reloads the counter with the current delay.
// - Read-only status at 0x0 holds all eight filtered levels.
// - Mode selections live at 0x1 and 0x2, four channels each, high channel on top.
// - Delay selections live at 0x3 and 0x4, four channels each, high channel on top.
`ifndef PCDF_PARAMS_SVH
`define PCDF_PARAMS_SVH

// Register offsets.
`define PCDF_ADDR_STATUS   8'h00
`define PCDF_ADDR_SEL_LOW  8'h01
`define PCDF_ADDR_SEL_HIGH 8'h02
`define PCDF_ADDR_DLY_LOW  8'h03
`define PCDF_ADDR_DLY_HIGH 8'h04

// Field layout: two bits per channel, four channels per register.
`define PCDF_FLD_W         2
`define PCDF_CH_PER_REG    4

// Reset values.
`define PCDF_CFG_RST       8'h00
`define PCDF_RD_UNMAPPED   8'h00

// Selected delays in milliseconds, one tick per millisecond.
`define PCDF_DLY0_MS       7'h00
`define PCDF_DLY1_MS       7'h0A
`define PCDF_DLY2_MS       7'h1E
`define PCDF_DLY3_MS       7'h64

// Timing: clock rate, fixed stage and tick period.
`define PCDF_CLK_MHZ       25
`define PCDF_LP_NS         4000
`define PCDF_LP_CYC        ((`PCDF_LP_NS * `PCDF_CLK_MHZ) / 1000)
`define PCDF_TICK_NS       1000000
`define PCDF_TICK_CYC      ((`PCDF_TICK_NS * `PCDF_CLK_MHZ) / 1000)

`endif

// ==== rtl/pcdf_pkg.sv ====
// Types shared by the per-channel debounce filter and its users.
package pcdf_pkg;

   // Filter modes after decoding the two-bit selection.
   typedef enum logic [1:0] {
      PCDF_DEGLITCH = 2'h0,
      PCDF_LOWPASS  = 2'h1,
      PCDF_BLANKING = 2'h2
   } pcdf_mode_t;

   // One channel's configuration as seen by its filter.
   typedef struct packed {
      logic [1:0] per_channel_filter_select;
      logic [1:0] per_channel_delay_select;
   } pcdf_chan_cfg_t;

   // Register access request from the host interface logic.
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcdf_reg_req_t;

   // Register read answer.
   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
   } pcdf_reg_rsp_t;

endpackage : pcdf_pkg

// ==== test/pcdf_checker_assertions.sv ====
// Port-level assertion checker for the per-channel debounce filter.
`timescale 1ns/1ps
`default_nettype none
module pcdf_checker #(
   parameter int         NUM_CH     = 8,
   parameter logic [7:0] HS_MASK    = 8'h00,
   parameter bit         SERIAL_CFG = 1'b1
) (
   // Clock and reset.
   input wire logic                                  mclk,
   input wire logic                                  sys_rst,
   // Observed ports.
   input wire logic [NUM_CH-1:0]                     field_in,
   input wire pcdf_pkg::pcdf_reg_req_t               reg_req,
   input wire pcdf_pkg::pcdf_reg_rsp_t               reg_rsp,
   input wire logic [NUM_CH-1:0]                     filtered_levels,
   input wire pcdf_pkg::pcdf_chan_cfg_t [NUM_CH-1:0] chan_cfg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // Counts cycles of raw input agreeing with channel 0; 200 covers the fixed stage lag.
   logic [7:0] match_cnt;
   always_ff @(posedge mclk)
   begin
      if (sys_rst || (field_in[0] != filtered_levels[0]))
      begin
         match_cnt <= 8'h00;
      end
      else if (match_cnt != 8'hC8)
      begin
         match_cnt <= match_cnt + 8'h01;
      end
   end

   // A bypass channel held still long enough to cross the sync flops.
   sequence s_hs_steady;
      (HS_MASK[7] == 1'b1) ##0 $stable(field_in[7]) [*4];
   endsequence

   property p_rd_answer;
      reg_req.rd_en |=> reg_rsp.rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read gave no answer");
   property p_rd_single;
      !reg_req.rd_en |=> !reg_rsp.rd_valid;
   endproperty
   a_rd_single: assert property (p_rd_single) else $error("answer without read");
   property p_status_read;
      reg_req.rd_en && (reg_req.addr == 8'h00) |=> reg_rsp.rd_data == $past(filtered_levels);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");
   property p_unmapped;
      reg_req.rd_en && (reg_req.addr > 8'h04) |=> reg_rsp.rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_mode_low;
      SERIAL_CFG && reg_req.wr_en && (reg_req.addr == 8'h01)
         |=> chan_cfg[3].per_channel_filter_select == $past(reg_req.wdata[7:6]);
   endproperty
   a_mode_low: assert property (p_mode_low) else $error("mode field misplaced");
   property p_dly_high;
      SERIAL_CFG && reg_req.wr_en && (reg_req.addr == 8'h04)
         |=> chan_cfg[4].per_channel_delay_select == $past(reg_req.wdata[1:0]);
   endproperty
   a_dly_high: assert property (p_dly_high) else $error("delay field misplaced");
   property p_rst_clear;
      SERIAL_CFG && $fell(sys_rst) |-> chan_cfg == '0;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("config not cleared");
   // Fixed variants must run the low-pass counter whatever the host writes.
   property p_fixed_mode;
      !SERIAL_CFG |-> chan_cfg[0].per_channel_filter_select == 2'h1;
   endproperty
   a_fixed_mode: assert property (p_fixed_mode) else $error("fixed variant not low-pass");
   property p_hs_pass;
      s_hs_steady |-> filtered_levels[7] == field_in[7];
   endproperty
   a_hs_pass: assert property (p_hs_pass) else $error("bypass channel lags");
   property p_quiet;
      match_cnt == 8'hC8 |=> $stable(filtered_levels[0]);
   endproperty
   a_quiet: assert property (p_quiet) else $error("level moved without cause");
endmodule : pcdf_checker

bind pcdf_filter pcdf_checker #(.NUM_CH(NUM_CH), .HS_MASK(HS_MASK), .SERIAL_CFG(SERIAL_CFG)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .field_in(field_in), .reg_req(reg_req),
   .reg_rsp(reg_rsp), .filtered_levels(filtered_levels), .chan_cfg(chan_cfg));
`default_nettype wire

// ==== test/pcdf_field_model.sv ====
// Field-side source model: switch levels presented to the filter inputs.
`timescale 1ns/1ps
`default_nettype none
module pcdf_field_model (
   // Clock used only to place changes away from the sampling edge.
   input  wire logic       mclk,
   // Switch levels.
   output var  logic [7:0] field_in
);
   // Switches start open; a driven level holds, so no release value is needed.
   initial field_in = 8'h00;

   // Moves one channel just after a falling edge.
   task automatic set_ch(input int ch, input logic val);
      @(negedge mclk);
      field_in[ch] = val;
   endtask : set_ch
endmodule : pcdf_field_model
`default_nettype wire

// ==== test/per_channel_debounce_filter_test.sv ====
// Self-checking bench for the per-channel debounce filter.
`timescale 1ns/1ps
`default_nettype none
module per_channel_debounce_filter_test;
   logic                           mclk;
   logic                           sys_rst;
   logic [7:0]                     field_in;
   pcdf_pkg::pcdf_reg_req_t        reg_req;
   pcdf_pkg::pcdf_reg_rsp_t        reg_rsp;
   logic [7:0]                     filtered_levels;
   pcdf_pkg::pcdf_chan_cfg_t [7:0] chan_cfg;
   logic [7:0]                     fixed_levels;
   pcdf_pkg::pcdf_chan_cfg_t [7:0] fixed_cfg;
   pcdf_pkg::pcdf_reg_rsp_t        fixed_rsp;
   int                             fail_count;
   int                             total_checks;
   int                             cyc;

   // Channel 7 bypasses; a 4-cycle tick keeps millisecond delays short.
   pcdf_filter #(.HS_MASK(8'h80), .TICK_CYCLES(4)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .field_in(field_in), .reg_req(reg_req),
      .reg_rsp(reg_rsp), .filtered_levels(filtered_levels), .chan_cfg(chan_cfg));
   // Variant without serial configuration, fixed on the 10 ms delay code.
   pcdf_filter #(.SERIAL_CFG(1'b0), .FIXED_DELAY(2'h1), .TICK_CYCLES(4)) dut_fixed (
      .mclk(mclk), .sys_rst(sys_rst), .field_in(field_in), .reg_req(reg_req),
      .reg_rsp(fixed_rsp), .filtered_levels(fixed_levels), .chan_cfg(fixed_cfg));
   pcdf_field_model u_field (.mclk(mclk), .field_in(field_in));

   // Clock and a hang guard far above the run length of about 4400 cycles.
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if ((fail_count == 0) && (total_checks > 0))
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   task automatic lvl(input int ch, input logic exp, input string what);
      chk({7'h00, filtered_levels[ch]}, {7'h00, exp}, what);
   endtask : lvl

   // Strobe cleared with a spare cycle so back-to-back calls never collide.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(negedge mclk);
      reg_req = '0;
      @(negedge mclk);
   endtask : wr

   // The answer is fixed at one cycle, so it is sampled at the next falling edge.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
      @(negedge mclk);
      reg_req = '0;
      chk({7'h00, reg_rsp.rd_valid}, 8'h01, "read answer");
      chk(reg_rsp.rd_data, exp, what);
      @(negedge mclk);
   endtask : rd_chk

   // Main sequence: registers first, then one channel per filter behaviour.
   initial
   begin
      sys_rst = 1'b1;
      reg_req = '0;
      fail_count = 0;
      total_checks = 0;
      idle(3);
      sys_rst = 1'b0;
      idle(1);
      chk(filtered_levels, 8'h00, "levels after reset");
      for (int a = 0; a < 5; a++)
      begin
         rd_chk(8'(a), 8'h00, "reset value");
      end
      rd_chk(8'h07, 8'h00, "unmapped read");
      wr(8'h01, 8'hE4);
      rd_chk(8'h01, 8'hE4, "mode low");
      chk({6'h00, chan_cfg[3].per_channel_filter_select}, 8'h03, "ch3 mode");
      wr(8'h00, 8'hFF);
      rd_chk(8'h00, 8'h00, "status not writable");
      wr(8'h01, 8'h91);
      wr(8'h03, 8'hFC);
      wr(8'h02, 8'hC0);
      wr(8'h04, 8'h40);
      rd_chk(8'h04, 8'h40, "delay high");
      chk(8'(chan_cfg[2]), 8'h07, "ch2 config");
      chk(8'(chan_cfg[7]), 8'h0D, "ch7 config");
      chk(8'(fixed_cfg[2]), 8'h05, "fixed config");
      chk(fixed_rsp.rd_data, 8'h00, "fixed ignores writes");
      u_field.set_ch(7, 1'b1);
      idle(4);
      lvl(7, 1'b1, "bypass follows");
      u_field.set_ch(0, 1'b1);
      idle(90);
      lvl(0, 1'b0, "fixed stage holds");
      idle(25);
      lvl(0, 1'b1, "no added delay");
      rd_chk(8'h00, 8'h81, "status levels");
      u_field.set_ch(1, 1'b1);
      idle(300);
      u_field.set_ch(1, 1'b0);
      idle(700);
      lvl(1, 1'b0, "short pulse dropped");
      u_field.set_ch(1, 1'b1);
      idle(400);
      lvl(1, 1'b0, "deglitch waits");
      idle(160);
      lvl(1, 1'b1, "deglitch after 100 ms");
      u_field.set_ch(2, 1'b1);
      idle(300);
      lvl(2, 1'b0, "low-pass counting");
      u_field.set_ch(2, 1'b0);
      idle(150);
      u_field.set_ch(2, 1'b1);
      idle(440);
      lvl(2, 1'b1, "credit kept");
      u_field.set_ch(3, 1'b1);
      idle(110);
      lvl(3, 1'b1, "leading edge passes");
      u_field.set_ch(3, 1'b0);
      idle(150);
      u_field.set_ch(3, 1'b1);
      idle(150);
      u_field.set_ch(3, 1'b0);
      idle(400);
      lvl(3, 1'b1, "blind while counting");
      idle(160);
      lvl(3, 1'b0, "catch-up at zero");
      // The catch-up reloads the blind time, so let it run out first.
      idle(400);
      u_field.set_ch(3, 1'b1);
      idle(110);
      lvl(3, 1'b1, "next change passes");
      // Channels 4 and 5 low-pass on the 10 and 30 ms codes, channel 6 blanking on code 11.
      wr(8'h02, 8'hF5);
      wr(8'h04, 8'h79);
      u_field.set_ch(4, 1'b1);
      u_field.set_ch(5, 1'b1);
      u_field.set_ch(6, 1'b1);
      idle(170);
      lvl(4, 1'b1, "10 ms delay");
      lvl(5, 1'b0, "30 ms still counting");
      lvl(6, 1'b1, "code 11 blanks");
      chk({5'h00, fixed_levels[6:4]}, 8'h07, "fixed low-pass delay");
      idle(80);
      lvl(5, 1'b1, "30 ms delay");
      rd_chk(8'h00, 8'hFF, "all levels");
      finish_test();
   end
endmodule : per_channel_debounce_filter_test
`default_nettype wire
